/* dcp_cke_power_state.sv */
`timescale 1ns/1ps
// Contract
// RULE1: next state from previous and present enable, prior state, command at edge.
// RULE2: power-down or self refresh with enable low twice holds state, pins ignored.
// RULE3: self refresh exits only on enable rise with chip-unselected command.
// RULE4: power-down entry and exit accompanied only by chip-unselected command.
// RULE5: power-down enters precharge type if banks closed, else active type.
// RULE6: self refresh entered only from all-idle, refresh with enable falling.
// RULE7: controller never enters self refresh during a read or write.
// RULE8: controller holds enable after a fall until the minimum pulse allows change.
// RULE9: controller drops enable only after setting gap and update wait elapse.
// RULE10: no internal refresh in any power-down mode.
// RULE11: termination ignored for transitions and unavailable in self refresh.
// RULE12: after self refresh exit, unselected during exit wait; reads after lock wait.
// RULE13: idle only with banks closed, no burst, enable high, exit waits done.
// RULE14: unlisted state and enable/command combinations are illegal.
// RULE15: controller uses idle slot command only for power saving exit or gear-down.
// RULE16: chip select high accepts no command; running operations continue.
// RULE17: clearing setting register 1 bit 0 disables the loop until set again.
// RULE18: controller keeps clock at or below loop-off maximum while loop is off.
// RULE19: loop-off uses read latency 10 and write latency 9.
// RULE20: loop-off strobe window starts additive plus read latency minus one after read.
// RULE21: loop-off changes only clock-to-strobe timing, not strobe-to-data.
// RULE22: controller trains read capture and realigns data in its own domain.
// RULE23: commands decoded from select, strobes and enable at rising clock edge.
// RULE24: controller never substitutes idle slot command for chip-unselected.
module dcp_cke_power_state #(
    parameter int READ_LATENCY = 16,
    parameter int WRITE_LATENCY = 12,
    parameter int ADDITIVE_LATENCY = 0,
    parameter int SELFREF_EXIT_WAIT = dcp_pkg::SELFREF_EXIT_WAIT_NCK,
    parameter int SELFREF_EXIT_LOCK_WAIT = dcp_pkg::SELFREF_EXIT_LOCK_WAIT_NCK,
    parameter int POWERDOWN_EXIT_WAIT = dcp_pkg::POWERDOWN_EXIT_WAIT_NCK,
    parameter int REFRESH_INTERVAL = dcp_pkg::REFRESH_INTERVAL_CYC
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link clock and command pins
    input wire logic link_clk,
    input wire logic clk_enable,
    input wire logic chip_select_n,
    input wire logic activate_strobe_low,
    input wire logic row_strobe_or_addr16,
    input wire logic column_strobe_or_addr15,
    input wire logic write_strobe_or_addr14,
    input wire logic [dcp_pkg::BANK_SEL_W-1:0] bank_sel,
    input wire logic addr0,
    input wire logic addr10,
    input wire logic termination_ctrl,
    // core status
    input wire logic illegal_clear,
    output logic in_precharge_pd,
    output logic in_active_pd,
    output logic in_self_refresh,
    output logic device_idle,
    output logic loop_off,
    output logic termination_on,
    output logic illegal_seen,
    output logic strobe_window_start,
    output logic refresh_tick
);

    // ****************************************************************
    // link side: command decode
    // ****************************************************************
    dcp_pkg::dcp_state_e state;
    dcp_pkg::dcp_state_e next_state;
    logic cke_prev;
    logic [15:0] bank_open;
    logic [5:0] burst_cnt;
    logic [5:0] rd_cnt;
    logic [dcp_pkg::CNT_W-1:0] exit_cnt;
    logic [dcp_pkg::CNT_W-1:0] lock_cnt;
    logic link_loop_off;
    logic illegal_tgl;
    logic strobe_tgl;

    wire cmd_sel = ~chip_select_n;                                            // [RULE16]
    wire cmd_des = chip_select_n;
    wire cmd_act = cmd_sel & ~activate_strobe_low;                            // [RULE23]
    wire cmd_op = cmd_sel & activate_strobe_low;
    wire cmd_mrs = cmd_op & ~row_strobe_or_addr16 & ~column_strobe_or_addr15
        & ~write_strobe_or_addr14;
    wire cmd_ref = cmd_op & ~row_strobe_or_addr16 & ~column_strobe_or_addr15
        & write_strobe_or_addr14;
    wire cmd_pre = cmd_op & ~row_strobe_or_addr16 & column_strobe_or_addr15
        & ~write_strobe_or_addr14;
    wire cmd_rd = cmd_op & row_strobe_or_addr16 & ~column_strobe_or_addr15
        & write_strobe_or_addr14;
    wire cmd_wr = cmd_op & row_strobe_or_addr16 & ~column_strobe_or_addr15
        & ~write_strobe_or_addr14;

    wire cke_rise = ~cke_prev & clk_enable;                                   // [RULE1]
    wire cke_fall = cke_prev & ~clk_enable;
    wire cke_high = cke_prev & clk_enable;
    wire in_on = (state == dcp_pkg::ST_ON);
    wire run = in_on & cke_high;
    wire exits_done = (exit_cnt == dcp_pkg::RST_CNT) & (lock_cnt == dcp_pkg::RST_CNT);
    wire idle_now = in_on & cke_prev & (bank_open == 16'h0000)              // [RULE13]
        & (burst_cnt == 6'h00) & (exit_cnt == dcp_pkg::RST_CNT);
    wire in_exit = in_on & (exit_cnt != dcp_pkg::RST_CNT);
    wire bank_hit = cmd_act | cmd_pre;

    // ****************************************************************
    // link side: latency selection
    // ****************************************************************
    wire [5:0] rl_sel = link_loop_off ? dcp_pkg::LOOP_OFF_READ_LATENCY       // [RULE19]
        : 6'(READ_LATENCY);
    wire [5:0] wl_sel = link_loop_off ? dcp_pkg::LOOP_OFF_WRITE_LATENCY
        : 6'(WRITE_LATENCY);
    wire [5:0] rd_start = 6'(ADDITIVE_LATENCY) + rl_sel                        // [RULE20]
        - (link_loop_off ? dcp_pkg::LOOP_OFF_EARLY : 6'h00);
    wire [5:0] next_burst = cmd_rd ? (6'(ADDITIVE_LATENCY) + rl_sel + dcp_pkg::BURST_CYCLES)
        : (6'(ADDITIVE_LATENCY) + wl_sel + dcp_pkg::BURST_CYCLES);

    // ****************************************************************
    // link side: illegal combinations
    // ****************************************************************
    wire pd_or_sr = ~in_on;
    wire bad_exit = pd_or_sr & cke_rise & ~cmd_des;                           // [RULE3] [RULE4]
    wire bad_entry = in_on & cke_fall & ~cmd_des & ~(cmd_ref & idle_now);    // [RULE4] [RULE14]
    wire bad_sr_entry = in_on & cke_fall & cmd_ref & (~idle_now | ~exits_done); // [RULE6]
    wire bad_exit_wait = in_exit & cke_high & ~cmd_des;                      // [RULE12]
    wire bad_early_read = run & (cmd_rd | termination_ctrl)
        & (lock_cnt != dcp_pkg::RST_CNT) & (exit_cnt == dcp_pkg::RST_CNT);
    wire bad_any = bad_exit | bad_entry | bad_sr_entry | bad_exit_wait | bad_early_read;

    // ****************************************************************
    // link side: state transitions
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            dcp_pkg::ST_ON: begin
                if (cke_fall & cmd_ref & idle_now & exits_done) begin
                    next_state = dcp_pkg::ST_SELFREF;                         // [RULE6]
                end else if (cke_fall & cmd_des) begin
                    if (bank_open != 16'h0000) begin
                        next_state = dcp_pkg::ST_PD_ACT;                      // [RULE5]
                    end else begin
                        next_state = dcp_pkg::ST_PD_PRE;                      // [RULE5]
                    end
                end
            end
            dcp_pkg::ST_PD_PRE, dcp_pkg::ST_PD_ACT, dcp_pkg::ST_SELFREF: begin
                if (cke_rise & cmd_des) begin
                    next_state = dcp_pkg::ST_ON;                              // [RULE3] [RULE4]
                end
            end
            default: begin
                next_state = dcp_pkg::ST_ON;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= dcp_pkg::ST_ON;
            cke_prev <= dcp_pkg::RST_CKE;
        end else begin
            state <= next_state;                                              // [RULE1] [RULE2]
            cke_prev <= clk_enable;
        end
    end

    // ****************************************************************
    // link side: exit wait counters
    // ****************************************************************
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            exit_cnt <= dcp_pkg::RST_CNT;
            lock_cnt <= dcp_pkg::RST_CNT;
        end else if (state == dcp_pkg::ST_SELFREF && next_state == dcp_pkg::ST_ON) begin
            exit_cnt <= dcp_pkg::CNT_W'(SELFREF_EXIT_WAIT);                   // [RULE12]
            lock_cnt <= dcp_pkg::CNT_W'(SELFREF_EXIT_LOCK_WAIT);
        end else if (pd_or_sr && next_state == dcp_pkg::ST_ON) begin
            exit_cnt <= dcp_pkg::CNT_W'(POWERDOWN_EXIT_WAIT);
        end else begin
            if (exit_cnt != dcp_pkg::RST_CNT) begin
                exit_cnt <= exit_cnt - 1'b1;
            end
            if (lock_cnt != dcp_pkg::RST_CNT) begin
                lock_cnt <= lock_cnt - 1'b1;
            end
        end
    end

    // ****************************************************************
    // link side: bank tracking, one flop per bank
    // ****************************************************************
    genvar gb;
    generate
        for (gb = 0; gb < 16; gb++) begin : g_bank
            wire this_bank = (bank_sel == dcp_pkg::BANK_SEL_W'(gb));
            always_ff @(posedge link_clk or negedge rst_n) begin
                if (!rst_n) begin
                    bank_open[gb] <= 1'b0;
                end else if (run && cmd_act && this_bank) begin
                    bank_open[gb] <= 1'b1;
                end else if (run && cmd_pre && (this_bank || addr10)) begin
                    bank_open[gb] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // link side: bursts, read strobe timing, loop control
    // ****************************************************************
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_cnt <= 6'h00;
            rd_cnt <= 6'h00;
            strobe_tgl <= 1'b0;
        end else begin
            if (run && (cmd_rd || cmd_wr)) begin
                burst_cnt <= next_burst;
            end else if (burst_cnt != 6'h00) begin
                burst_cnt <= burst_cnt - 1'b1;                                // [RULE16]
            end
            if (run && cmd_rd) begin
                rd_cnt <= rd_start;                                           // [RULE20] [RULE21]
            end else if (rd_cnt != 6'h00) begin
                rd_cnt <= rd_cnt - 1'b1;
            end
            if (rd_cnt == 6'h01) begin
                strobe_tgl <= ~strobe_tgl;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_loop_off <= dcp_pkg::RST_LOOP_OFF;
            illegal_tgl <= 1'b0;
        end else begin
            if (run && cmd_mrs && bank_sel == dcp_pkg::SETTING_REG_1_SEL) begin
                link_loop_off <= ~addr0;                                      // [RULE17]
            end
            if (bad_any) begin
                illegal_tgl <= ~illegal_tgl;                                  // [RULE14]
            end
        end
    end

    // ****************************************************************
    // crossing into the core domain
    // ****************************************************************
    wire [7:0] link_levels = {
        illegal_tgl,
        strobe_tgl,
        termination_ctrl & (state != dcp_pkg::ST_SELFREF),                   // [RULE11]
        link_loop_off,
        idle_now & exits_done,
        state == dcp_pkg::ST_SELFREF,
        state == dcp_pkg::ST_PD_ACT,
        state == dcp_pkg::ST_PD_PRE
    };
    logic [7:0] link_levels_q;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [1:0] tgl_seen;
    logic [dcp_pkg::CNT_W-1:0] ref_cnt;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_levels_q <= 8'h00;
        end else begin
            link_levels_q <= link_levels;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= link_levels_q;
            sync2 <= sync1;
        end
    end

    wire illegal_evt = sync2[7] ^ tgl_seen[1];
    wire strobe_evt = sync2[6] ^ tgl_seen[0];
    wire ref_due = (ref_cnt == dcp_pkg::CNT_W'(REFRESH_INTERVAL - 1));

    // ****************************************************************
    // core side: outputs and self refresh timer
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_seen <= 2'h0;
            in_precharge_pd <= 1'b0;
            in_active_pd <= 1'b0;
            in_self_refresh <= 1'b0;
            device_idle <= 1'b0;
            loop_off <= dcp_pkg::RST_LOOP_OFF;
            termination_on <= 1'b0;
            strobe_window_start <= 1'b0;
        end else begin
            tgl_seen <= {sync2[7], sync2[6]};
            in_precharge_pd <= sync2[0];
            in_active_pd <= sync2[1];
            in_self_refresh <= sync2[2];
            device_idle <= sync2[3];
            loop_off <= sync2[4];
            termination_on <= sync2[5];
            strobe_window_start <= strobe_evt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            illegal_seen <= 1'b0;
        end else if (illegal_evt) begin
            illegal_seen <= 1'b1;
        end else if (illegal_clear) begin
            illegal_seen <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt <= dcp_pkg::RST_CNT;
            refresh_tick <= 1'b0;
        end else if (!sync2[2]) begin
            ref_cnt <= dcp_pkg::RST_CNT;                                      // [RULE10]
            refresh_tick <= 1'b0;
        end else begin
            ref_cnt <= ref_due ? dcp_pkg::RST_CNT : ref_cnt + 1'b1;
            refresh_tick <= ref_due;
        end
    end

endmodule // dcp_cke_power_state

/* dcp_pkg.sv */
package dcp_pkg;

    // ****************************************************************
    // link side states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_ON,
        ST_PD_PRE,
        ST_PD_ACT,
        ST_SELFREF
    } dcp_state_e;

    // ****************************************************************
    // widths and field positions
    // ****************************************************************
    localparam int BANK_SEL_W = 4;
    localparam int CNT_W = 12;
    localparam logic [BANK_SEL_W-1:0] SETTING_REG_1_SEL = 4'h1;
    localparam int LOCK_LOOP_DISABLE_POS = 0;
    localparam int AUTO_PRE_POS = 10;

    // ****************************************************************
    // latencies in link clock cycles
    // ****************************************************************
    localparam logic [5:0] LOOP_OFF_READ_LATENCY = 6'h0A;
    localparam logic [5:0] LOOP_OFF_WRITE_LATENCY = 6'h09;
    localparam logic [5:0] BURST_CYCLES = 6'h04;
    localparam logic [5:0] LOOP_OFF_EARLY = 6'h01;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_LOOP_OFF = 1'b0;
    localparam logic RST_CKE = 1'b0;
    localparam logic [CNT_W-1:0] RST_CNT = 12'h000;

    // ****************************************************************
    // default counts in link clock cycles
    // ****************************************************************
    localparam int SELFREF_EXIT_WAIT_NCK = 24;
    localparam int SELFREF_EXIT_LOCK_WAIT_NCK = 597;
    localparam int POWERDOWN_EXIT_WAIT_NCK = 8;

    // ****************************************************************
    // internal refresh interval in ns and core cycles
    // ****************************************************************
    localparam int CORE_CLK_PERIOD_NS = 20;
    localparam int REFRESH_INTERVAL_NS = 7800;
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CORE_CLK_PERIOD_NS;

endpackage : dcp_pkg

/* dcp_cke_power_state_sva.sv */
`timescale 1ns/1ps
module dcp_checker #(
    parameter int REFRESH_INTERVAL = 8
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic illegal_clear,
    input wire logic in_precharge_pd,
    input wire logic in_active_pd,
    input wire logic in_self_refresh,
    input wire logic device_idle,
    input wire logic termination_on,
    input wire logic illegal_seen,
    input wire logic strobe_window_start,
    input wire logic refresh_tick
);
    // ********
    // cycles between refresh ticks within one self refresh stay
    // ********
    logic [15:0] gap;
    logic had_tick;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 16'h0000;
            had_tick <= 1'b0;
        end else begin
            gap <= refresh_tick ? 16'h0001 : gap + 16'h0001;
            had_tick <= in_self_refresh && (had_tick || refresh_tick);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    one_state_a: assert property ($onehot0({in_precharge_pd, in_active_pd, in_self_refresh}))
        else $error("two power states at once");
    idle_awake_a: assert property (device_idle |-> !(in_precharge_pd || in_active_pd || in_self_refresh))
        else $error("idle while asleep");
    sr_term_off_a: assert property (in_self_refresh |-> !termination_on)
        else $error("termination on in self refresh");
    pd_no_refresh_a: assert property (refresh_tick |-> !in_precharge_pd && !in_active_pd)
        else $error("refresh in power-down");
    tick_single_a: assert property (refresh_tick |=> !refresh_tick)
        else $error("refresh tick longer than a cycle");
    tick_period_a: assert property (refresh_tick && had_tick |-> gap == 16'(REFRESH_INTERVAL))
        else $error("refresh tick spacing wrong");
    strobe_single_a: assert property (strobe_window_start |=> !strobe_window_start)
        else $error("strobe start longer than a cycle");
    illegal_hold_a: assert property (illegal_seen && !illegal_clear |=> illegal_seen)
        else $error("illegal flag dropped");
endmodule // dcp_checker

bind dcp_cke_power_state dcp_checker #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .illegal_clear(illegal_clear),
    .in_precharge_pd(in_precharge_pd), .in_active_pd(in_active_pd),
    .in_self_refresh(in_self_refresh), .device_idle(device_idle),
    .termination_on(termination_on), .illegal_seen(illegal_seen),
    .strobe_window_start(strobe_window_start), .refresh_tick(refresh_tick)
);

/* dcp_ctrl_model.sv */
`timescale 1ns/1ps
module dcp_ctrl_model (
    // link clock
    input wire logic link_clk,
    // command pins
    output logic clk_enable,
    output logic chip_select_n,
    output logic [3:0] strobes,
    output logic [dcp_pkg::BANK_SEL_W-1:0] bank_sel,
    output logic addr0,
    output logic addr10,
    output logic termination_ctrl
);
    initial begin
        clk_enable = 1'b0;
        chip_select_n = 1'b1;
        strobes = 4'hF;
        bank_sel = 4'h0;
        addr0 = 1'b1;
        addr10 = 1'b0;
        termination_ctrl = 1'b0;
    end
    // unselected slot: strobe, bank and address pins are scrambled since they are not looked at
    task automatic des(input logic cke);
        @(posedge link_clk);
        #2;
        clk_enable = cke;
        chip_select_n = 1'b1;
        strobes = ~strobes;
        bank_sel = ~bank_sel;
        addr0 = ~addr0;
        addr10 = ~addr10;
    endtask
    task automatic cmd(input logic cke, input logic [3:0] pins, input logic [3:0] bank,
                       input logic a10, input logic a0);
        @(posedge link_clk);
        #2;
        clk_enable = cke;
        chip_select_n = 1'b0;
        strobes = pins;
        bank_sel = bank;
        addr10 = a10;
        addr0 = a0;
    endtask
    task automatic idle(input logic cke, input int n);
        repeat (n) des(cke);
    endtask
    task automatic term(input logic v);
        @(posedge link_clk);
        #2;
        termination_ctrl = v;
    endtask
endmodule // dcp_ctrl_model

/* dcp_cke_power_state_tb_top.sv */
`timescale 1ns/1ps
module dcp_cke_power_state_tb_top;
    // ********
    // clocks, wiring, bookkeeping
    // ********
    localparam logic [3:0] C_NOP = 4'hF, C_ACT = 4'h0, C_PRE = 4'hA, C_REF = 4'h9;
    localparam logic [3:0] C_MRS = 4'h8, C_RD = 4'hD, C_WR = 4'hC;
    logic core_clk, link_clk, rst_n, illegal_clear, clk_enable, chip_select_n;
    logic addr0, addr10, termination_ctrl, strobe_window_start, refresh_tick;
    logic in_precharge_pd, in_active_pd, in_self_refresh, device_idle, loop_off;
    logic termination_on, illegal_seen;
    logic [3:0] strobes, bank_sel;
    int failures = 0, n_tests = 0, ticks = 0;
    realtime t_strobe, t0;
    wire logic [6:0] st = {illegal_seen, termination_on, loop_off, device_idle,
                           in_self_refresh, in_active_pd, in_precharge_pd};
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #4;
        forever #15 link_clk = ~link_clk;
    end
    always @(posedge core_clk) if (refresh_tick === 1'b1) ticks++;
    always @(posedge core_clk) if (strobe_window_start === 1'b1) t_strobe = $realtime;
    dcp_ctrl_model ctl (.link_clk(link_clk), .clk_enable(clk_enable),
        .chip_select_n(chip_select_n), .strobes(strobes), .bank_sel(bank_sel),
        .addr0(addr0), .addr10(addr10), .termination_ctrl(termination_ctrl));
    dcp_cke_power_state #(.SELFREF_EXIT_LOCK_WAIT(20), .REFRESH_INTERVAL(8)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .clk_enable(clk_enable),
        .chip_select_n(chip_select_n), .activate_strobe_low(strobes[3]),
        .row_strobe_or_addr16(strobes[2]), .column_strobe_or_addr15(strobes[1]),
        .write_strobe_or_addr14(strobes[0]), .bank_sel(bank_sel), .addr0(addr0),
        .addr10(addr10), .termination_ctrl(termination_ctrl), .illegal_clear(illegal_clear),
        .in_precharge_pd(in_precharge_pd), .in_active_pd(in_active_pd),
        .in_self_refresh(in_self_refresh), .device_idle(device_idle), .loop_off(loop_off),
        .termination_on(termination_on), .illegal_seen(illegal_seen),
        .strobe_window_start(strobe_window_start), .refresh_tick(refresh_tick));
    // ********
    // tasks
    // ********
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_bit(input int idx, input logic val, input int lim);
        int k;
        k = 0;
        while (st[idx] !== val && k < lim) begin
            @(posedge core_clk);
            #2;
            k++;
        end
        if (k >= lim) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, st, val);
            tally_and_finish();
        end
    endtask
    // read, then see the strobe start land lat link cycles later plus the crossing
    task automatic read_delay(input int lat);
        t_strobe = 0;
        ctl.cmd(1'b1, C_RD, 4'h0, 1'b0, 1'b0);
        t0 = $realtime - 2;
        ctl.idle(1'b1, lat + 6);
        check({6'h00, (t_strobe >= t0 + lat * 30 + 120) && (t_strobe <= t0 + lat * 30 + 140)},
              7'h01);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        rst_n = 1'b0;
        illegal_clear = 1'b0;
        repeat (6) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        check(st, 7'h00);
        ctl.idle(1'b0, 2);
        ctl.idle(1'b1, 12);
        wait_bit(3, 1'b1, 200);
        check(st, 7'h08);
        read_delay(16);
        ctl.cmd(1'b1, C_MRS, 4'h1, 1'b0, 1'b0);
        ctl.idle(1'b1, 4);
        wait_bit(4, 1'b1, 50);
        read_delay(9);
        $display("test latency done");
        ticks = 0;
        ctl.des(1'b0);
        wait_bit(0, 1'b1, 20);
        ctl.cmd(1'b0, C_RD, 4'h5, 1'b1, 1'b1);
        ctl.idle(1'b0, 6);
        check(st, 7'h11);
        check(7'(ticks), 7'h00);
        ctl.idle(1'b1, 12);
        wait_bit(3, 1'b1, 60);
        check(st, 7'h18);
        ctl.cmd(1'b1, C_ACT, 4'h2, 1'b0, 1'b0);
        ctl.idle(1'b1, 2);
        ctl.des(1'b0);
        wait_bit(1, 1'b1, 20);
        ctl.idle(1'b0, 3);
        check(st, 7'h12);
        ctl.idle(1'b1, 12);
        check(st, 7'h10);
        ctl.cmd(1'b1, C_PRE, 4'h0, 1'b1, 1'b0);
        ctl.idle(1'b1, 4);
        wait_bit(3, 1'b1, 60);
        check(st, 7'h18);
        ctl.cmd(1'b1, C_WR, 4'h3, 1'b0, 1'b0);
        ctl.idle(1'b1, 5);
        check(st, 7'h10);
        wait_bit(3, 1'b1, 60);
        check(st, 7'h18);
        $display("test power-down done");
        ctl.cmd(1'b0, C_NOP, 4'h0, 1'b0, 1'b0);
        ctl.cmd(1'b0, C_NOP, 4'h0, 1'b0, 1'b0);
        ctl.idle(1'b1, 12);
        wait_bit(3, 1'b1, 60);
        check(st, 7'h58);
        @(posedge core_clk);
        #2;
        illegal_clear = 1'b1;
        repeat (2) @(posedge core_clk);
        #2;
        illegal_clear = 1'b0;
        check(st, 7'h18);
        $display("test illegal done");
        ctl.term(1'b1);
        ctl.idle(1'b1, 3);
        check(st, 7'h38);
        ctl.cmd(1'b0, C_REF, 4'h0, 1'b0, 1'b0);
        wait_bit(2, 1'b1, 20);
        ticks = 0;
        repeat (40) @(posedge core_clk);
        #2;
        check(st, 7'h14);
        check({6'h00, ticks inside {4, 5}}, 7'h01);
        ctl.idle(1'b1, 24);
        wait_bit(3, 1'b1, 100);
        check(st, 7'h38);
        ticks = 0;
        repeat (20) @(posedge core_clk);
        check(7'(ticks), 7'h00);
        $display("test self refresh done");
        tally_and_finish();
    end
endmodule // dcp_cke_power_state_tb_top
